// [common/dcff_params.svh]
// Constants for the dual-clock nine-bit buffer with programmable flags.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef DCFF_PARAMS_SVH
`define DCFF_PARAMS_SVH

`define DCFF_DATA_W       9
`define DCFF_DEPTH        64
`define DCFF_OFS_W        18
`define DCFF_LO_MSB       8
`define DCFF_LO_LSB       0
`define DCFF_HI_MSB       17
`define DCFF_HI_LSB       9
`define DCFF_AE_RST       18'h00007
`define DCFF_AF_RST       18'h00007
`define DCFF_FULL_N_RST   1'b1
`define DCFF_AFULL_N_RST  1'b1
`define DCFF_EMPTY_N_RST  1'b0
`define DCFF_AEMPTY_N_RST 1'b0
`define DCFF_DOUT_RST     9'h000

`endif

// [common/dcff_pkg.sv]
// Types shared by the dual-clock buffer modules.
// Assumes nothing of its surroundings.
package dcff_pkg;

	typedef enum logic [1:0] {
		DCFF_STEP_AE_LO = 2'b00,
		DCFF_STEP_AE_HI = 2'b01,
		DCFF_STEP_AF_LO = 2'b10,
		DCFF_STEP_AF_HI = 2'b11
	} dcff_step_t;

	typedef enum logic {
		DCFF_MODE_PFLAG = 1'b0,
		DCFF_MODE_DUAL  = 1'b1
	} dcff_mode_t;

endpackage

// [verilog/dcff_sync.sv]
// Two flip-flop synchroniser for a level or a Gray-coded word.
// Assumes the input changes at most one bit at a time when wider than one.
`timescale 1ns/10ps
module dcff_sync #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] hold_q;
	logic [W-1:0] hold_d;

	always_comb begin
		meta_d = d;
		hold_d = meta_q;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RST_VAL;
			hold_q <= RST_VAL;
		end else begin
			meta_q <= meta_d;
			hold_q <= hold_d;
		end
	end

	assign q = hold_q;
endmodule

// [verilog/dcff_ram.sv]
// Storage array: one clocked write port, one direct read port.
// Assumes the reader only addresses words the flags declare valid.
`timescale 1ns/10ps
module dcff_ram #(
	parameter int W     = 9,
	parameter int DEPTH = 64,
	parameter int AW    = 6
) (
	input  wire logic          wclk,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [W-1:0]  rdata
);
	logic [W-1:0] mem [DEPTH];

	always_ff @(posedge wclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// No stage between array and reader
	assign rdata = mem[raddr];
endmodule

// [verilog/dcff_top.sv]
// Dual-clock nine-bit buffer with empty, full and programmable almost flags.
// Assumes clk is the write clock, rd_clk the read clock, resetn held 3+ edges of each.
`timescale 1ns/10ps
`include "dcff_params.svh"
module dcff_top #(
	parameter int DEPTH = `DCFF_DEPTH
) (
	input  wire logic                    clk,
	input  wire logic                    resetn,
	input  wire logic                    rd_clk,
	input  wire logic [`DCFF_DATA_W-1:0] din,
	input  wire logic                    wr_en_a_n,
	input  wire logic                    wr_en_b_or_load_n,
	input  wire logic                    rd_en_a_n,
	input  wire logic                    rd_en_b_n,
	input  wire logic                    oe_n,
	output logic      [`DCFF_DATA_W-1:0] dout,
	output logic                         dout_oe,
	output logic                         empty_n,
	output logic                         almost_empty_n,
	output logic                         full_n,
	output logic                         almost_full_n
);
	localparam int AW = $clog2(DEPTH);
	localparam int PW = AW + 1;
	localparam int DW = `DCFF_DATA_W;
	localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);

	logic                wrst_n;
	logic                rrst_n;
	logic [DW+1:0]       wpin_s;
	logic [3:0]          rpin_s;
	logic [DW-1:0]       din_s;
	logic                wa_n_s;
	logic                wb_s;
	logic                ra_n_s;
	logic                rb_n_s;
	logic                oe_n_s;
	logic                ld_r_s;
	logic                mode_r_s;
	logic                tgl_r_s;
	logic [PW-1:0]       rgray_w_s;
	logic [PW-1:0]       wgray_r_s;
	logic [PW-1:0]       rbin_w;
	logic [PW-1:0]       wbin_r;
	logic [DW-1:0]       ram_rdata;
	logic [PW-1:0]       rbin_q;
	logic [PW-1:0]       rgray_q;

	dcff_sync #(.W(1), .RST_VAL(1'b0)) u_wrst (
		.clk(clk), .rst_n(resetn), .d(1'b1), .q(wrst_n)
	);
	dcff_sync #(.W(1), .RST_VAL(1'b0)) u_rrst (
		.clk(rd_clk), .rst_n(resetn), .d(1'b1), .q(rrst_n)
	);
	dcff_sync #(.W(DW+2), .RST_VAL('0)) u_wpin (
		.clk(clk), .rst_n(1'b1), .d({din, wr_en_a_n, wr_en_b_or_load_n}), .q(wpin_s)
	);
	dcff_sync #(.W(4), .RST_VAL('0)) u_rpin (
		.clk(rd_clk), .rst_n(1'b1), .d({rd_en_a_n, rd_en_b_n, oe_n, wr_en_b_or_load_n}),
		.q(rpin_s)
	);
	assign din_s  = wpin_s[DW+1:2];
	assign wa_n_s = wpin_s[1];
	assign wb_s   = wpin_s[0];
	assign ra_n_s = rpin_s[3];
	assign rb_n_s = rpin_s[2];
	assign oe_n_s = rpin_s[1];
	assign ld_r_s = rpin_s[0];

	// Write domain state
	dcff_pkg::dcff_mode_t   mode_q;
	dcff_pkg::dcff_mode_t   mode_d;
	dcff_pkg::dcff_step_t   wstep_q;
	dcff_pkg::dcff_step_t   wstep_d;
	logic [PW-1:0]          wbin_q;
	logic [PW-1:0]          wbin_d;
	logic [PW-1:0]          wgray_q;
	logic [PW-1:0]          wgray_d;
	logic [PW-1:0]          fill_w;
	logic                   full_n_q;
	logic                   full_n_d;
	logic                   afull_n_q;
	logic                   afull_n_d;
	logic [`DCFF_OFS_W-1:0] ae_q;
	logic [`DCFF_OFS_W-1:0] ae_d;
	logic [`DCFF_OFS_W-1:0] af_q;
	logic [`DCFF_OFS_W-1:0] af_d;
	logic                   tgl_q;
	logic                   tgl_d;
	logic                   dual;
	logic                   load_w;
	logic                   data_req;
	logic                   ofs_wr;
	logic                   push;

	// Strap is caught while the write side is held in reset
	always_comb begin
		mode_d = wrst_n ? mode_q : dcff_pkg::dcff_mode_t'(wb_s);
	end

	always_ff @(posedge clk) begin
		mode_q <= mode_d;
	end

	dcff_sync #(.W(PW), .RST_VAL('0)) u_rgray_w (
		.clk(clk), .rst_n(wrst_n), .d(rgray_q), .q(rgray_w_s)
	);

	genvar gi;
	generate
		for (gi = 0; gi < PW; gi++) begin : g_g2b
			assign rbin_w[gi] = ^rgray_w_s[PW-1:gi];
			assign wbin_r[gi] = ^wgray_r_s[PW-1:gi];
		end
	endgenerate

	assign dual     = (mode_q == dcff_pkg::DCFF_MODE_DUAL);
	assign load_w   = !dual && !wb_s;
	// Pin B must be high in both modes: dual enable, or load released
	assign data_req = !wa_n_s && wb_s;
	assign ofs_wr   = !wa_n_s && load_w;
	assign push     = data_req && full_n_q;

	always_comb begin
		wbin_d    = wbin_q + PW'(push);
		wgray_d   = (wbin_d >> 1) ^ wbin_d;
		full_n_d  = !(wgray_d == {~rgray_w_s[PW-1:PW-2], rgray_w_s[PW-3:0]});
		fill_w    = wbin_d - rbin_w;
		afull_n_d = !(fill_w >= (DEPTH_P - {1'b0, af_q[AW-1:0]}));
		ae_d      = ae_q;
		af_d      = af_q;
		tgl_d     = tgl_q;
		wstep_d   = wstep_q;
		if (!load_w) begin
			wstep_d = dcff_pkg::DCFF_STEP_AE_LO;
		end else if (ofs_wr) begin
			tgl_d   = !tgl_q;
			wstep_d = dcff_pkg::dcff_step_t'(wstep_q + 2'h1);
			unique case (wstep_q)
				dcff_pkg::DCFF_STEP_AE_LO: ae_d[`DCFF_LO_MSB:`DCFF_LO_LSB] = din_s;
				dcff_pkg::DCFF_STEP_AE_HI: ae_d[`DCFF_HI_MSB:`DCFF_HI_LSB] = din_s;
				dcff_pkg::DCFF_STEP_AF_LO: af_d[`DCFF_LO_MSB:`DCFF_LO_LSB] = din_s;
				dcff_pkg::DCFF_STEP_AF_HI: af_d[`DCFF_HI_MSB:`DCFF_HI_LSB] = din_s;
			endcase
		end
	end

	always_ff @(posedge clk or negedge wrst_n) begin
		if (!wrst_n) begin
			wbin_q    <= '0;
			wgray_q   <= '0;
			full_n_q  <= `DCFF_FULL_N_RST;
			afull_n_q <= `DCFF_AFULL_N_RST;
			ae_q      <= `DCFF_AE_RST;
			af_q      <= `DCFF_AF_RST;
			tgl_q     <= 1'b0;
			wstep_q   <= dcff_pkg::DCFF_STEP_AE_LO;
		end else begin
			wbin_q    <= wbin_d;
			wgray_q   <= wgray_d;
			full_n_q  <= full_n_d;
			afull_n_q <= afull_n_d;
			ae_q      <= ae_d;
			af_q      <= af_d;
			tgl_q     <= tgl_d;
			wstep_q   <= wstep_d;
		end
	end

	dcff_ram #(.W(DW), .DEPTH(DEPTH), .AW(AW)) u_ram (
		.wclk  (clk),
		.we    (push),
		.waddr (wbin_q[AW-1:0]),
		.wdata (din_s),
		.raddr (rbin_q[AW-1:0]),
		.rdata (ram_rdata)
	);

	// Read domain state
	dcff_pkg::dcff_step_t   rstep_q;
	dcff_pkg::dcff_step_t   rstep_d;
	logic [PW-1:0]          rbin_d;
	logic [PW-1:0]          rgray_d;
	logic [PW-1:0]          fill_r;
	logic                   empty_n_q;
	logic                   empty_n_d;
	logic                   aempty_n_q;
	logic                   aempty_n_d;
	logic [DW-1:0]          dout_q;
	logic [DW-1:0]          dout_d;
	logic                   oe_q;
	logic                   oe_d;
	logic [`DCFF_OFS_W-1:0] ae_r_q;
	logic [`DCFF_OFS_W-1:0] ae_r_d;
	logic [`DCFF_OFS_W-1:0] af_r_q;
	logic [`DCFF_OFS_W-1:0] af_r_d;
	logic                   seen_q;
	logic                   seen_d;
	logic                   rd_req;
	logic                   load_r;
	logic                   pop;
	logic                   ofs_rd;

	dcff_sync #(.W(PW), .RST_VAL('0)) u_wgray_r (
		.clk(rd_clk), .rst_n(rrst_n), .d(wgray_q), .q(wgray_r_s)
	);
	dcff_sync #(.W(1), .RST_VAL(1'b1)) u_mode_r (
		.clk(rd_clk), .rst_n(rrst_n), .d(mode_q), .q(mode_r_s)
	);
	dcff_sync #(.W(1), .RST_VAL(1'b0)) u_tgl_r (
		.clk(rd_clk), .rst_n(rrst_n), .d(tgl_q), .q(tgl_r_s)
	);

	assign rd_req = !ra_n_s && !rb_n_s;
	assign load_r = !mode_r_s && !ld_r_s;
	assign pop    = rd_req && !load_r && empty_n_q;
	assign ofs_rd = rd_req && load_r;

	always_comb begin
		rbin_d     = rbin_q + PW'(pop);
		rgray_d    = (rbin_d >> 1) ^ rbin_d;
		empty_n_d  = !(rgray_d == wgray_r_s);
		fill_r     = wbin_r - rbin_d;
		aempty_n_d = !(fill_r <= {1'b0, ae_r_q[AW-1:0]});
		oe_d       = !oe_n_s;
		seen_d     = tgl_r_s;
		ae_r_d     = ae_r_q;
		af_r_d     = af_r_q;
		// Offsets are stable by the time their toggle lands here
		if (tgl_r_s != seen_q) begin
			ae_r_d = ae_q;
			af_r_d = af_q;
		end
		dout_d  = dout_q;
		rstep_d = rstep_q;
		if (pop) begin
			dout_d = ram_rdata;
		end
		if (!load_r) begin
			rstep_d = dcff_pkg::DCFF_STEP_AE_LO;
		end else if (ofs_rd) begin
			rstep_d = dcff_pkg::dcff_step_t'(rstep_q + 2'h1);
			unique case (rstep_q)
				dcff_pkg::DCFF_STEP_AE_LO: dout_d = ae_r_q[`DCFF_LO_MSB:`DCFF_LO_LSB];
				dcff_pkg::DCFF_STEP_AE_HI: dout_d = ae_r_q[`DCFF_HI_MSB:`DCFF_HI_LSB];
				dcff_pkg::DCFF_STEP_AF_LO: dout_d = af_r_q[`DCFF_LO_MSB:`DCFF_LO_LSB];
				dcff_pkg::DCFF_STEP_AF_HI: dout_d = af_r_q[`DCFF_HI_MSB:`DCFF_HI_LSB];
			endcase
		end
	end

	always_ff @(posedge rd_clk or negedge rrst_n) begin
		if (!rrst_n) begin
			rbin_q     <= '0;
			rgray_q    <= '0;
			empty_n_q  <= `DCFF_EMPTY_N_RST;
			aempty_n_q <= `DCFF_AEMPTY_N_RST;
			dout_q     <= `DCFF_DOUT_RST;
			oe_q       <= 1'b0;
			ae_r_q     <= `DCFF_AE_RST;
			af_r_q     <= `DCFF_AF_RST;
			seen_q     <= 1'b0;
			rstep_q    <= dcff_pkg::DCFF_STEP_AE_LO;
		end else begin
			rbin_q     <= rbin_d;
			rgray_q    <= rgray_d;
			empty_n_q  <= empty_n_d;
			aempty_n_q <= aempty_n_d;
			dout_q     <= dout_d;
			oe_q       <= oe_d;
			ae_r_q     <= ae_r_d;
			af_r_q     <= af_r_d;
			seen_q     <= seen_d;
			rstep_q    <= rstep_d;
		end
	end

	assign dout           = dout_q;
	assign dout_oe        = oe_q;
	assign empty_n        = empty_n_q;
	assign almost_empty_n = aempty_n_q;
	assign full_n         = full_n_q;
	assign almost_full_n  = afull_n_q;

	// Checks on the write side
	chk_full_blocks_push: assert property (@(posedge clk) disable iff (!wrst_n)
		(!full_n_q && data_req) |=> $stable(wbin_q))
		else $error("write pointer moved while full");
	chk_push_advances: assert property (@(posedge clk) disable iff (!wrst_n)
		push |=> (wbin_q == $past(wbin_q) + PW'(1)))
		else $error("accepted write did not advance pointer");
	chk_dual_needs_b: assert property (@(posedge clk) disable iff (!wrst_n)
		(dual && !wb_s) |=> $stable(wbin_q))
		else $error("dual mode wrote with enable B low");
	chk_ofs_defaults: assert property (@(posedge clk) disable iff (!resetn)
		$rose(wrst_n) |-> (ae_q == `DCFF_AE_RST && af_q == `DCFF_AF_RST))
		else $error("offsets not at default after reset");
	chk_ofs_step: assert property (@(posedge clk) disable iff (!wrst_n)
		(ofs_wr && load_w) |=> (wstep_q == dcff_pkg::dcff_step_t'($past(wstep_q) + 2'h1)))
		else $error("offset sequencer did not step");
	chk_full_implies_af: assert property (@(posedge clk) disable iff (!wrst_n)
		!full_n_q |-> !afull_n_q)
		else $error("full without almost-full");

	// Checks on the read side
	chk_reset_rd_flags: assert property (@(posedge rd_clk) disable iff (!resetn)
		$rose(rrst_n) |-> (!empty_n_q && !aempty_n_q && rbin_q == '0))
		else $error("read flags not reset");
	chk_empty_no_pop: assert property (@(posedge rd_clk) disable iff (!rrst_n)
		(!empty_n_q && rd_req) |=> $stable(rbin_q))
		else $error("read pointer moved while empty");
	chk_pop_dout: assert property (@(posedge rd_clk) disable iff (!rrst_n)
		pop |=> (dout_q == $past(ram_rdata)))
		else $error("popped word not presented");
	chk_oe_follow: assert property (@(posedge rd_clk) disable iff (!rrst_n)
		oe_n_s |=> !oe_q)
		else $error("data bus driven with output enable high");

	cov_full: cover property (@(posedge clk) disable iff (!wrst_n) $fell(full_n_q));
	cov_empty_after_data: cover property (@(posedge rd_clk) disable iff (!rrst_n)
		empty_n_q ##1 !empty_n_q);
	cov_ofs_load: cover property (@(posedge clk) disable iff (!wrst_n)
		ofs_wr && wstep_q == dcff_pkg::DCFF_STEP_AF_HI);
endmodule

// [bench/dcff_far_end.sv]
// Read-side partner: drives read enables and output enable, resolves the data bus.
// Assumes rd_clk runs freely and the bench calls pop only after reset.
`timescale 1ns/10ps
module dcff_far_end (
	input  wire logic       rd_clk,
	input  wire logic       want_oe,
	input  wire logic [8:0] dout,
	input  wire logic       dout_oe,
	output logic            rd_en_a_n,
	output logic            rd_en_b_n,
	output logic            oe_n,
	output wire       [8:0] q_bus
);
	// Released bus floats
	assign q_bus = dout_oe ? dout : 9'hzzz;
	initial begin
		rd_en_a_n = 1'b1;
		rd_en_b_n = 1'b1;
		oe_n = 1'b1;
	end
	always @(posedge rd_clk) begin
		oe_n <= !want_oe;
	end
	// One read: both enables low for a single edge, then collect the word
	task pop(output logic [8:0] d);
		@(posedge rd_clk);
		rd_en_a_n <= 1'b0;
		rd_en_b_n <= 1'b0;
		@(posedge rd_clk);
		rd_en_a_n <= 1'b1;
		rd_en_b_n <= 1'b1;
		repeat (5) @(posedge rd_clk);
		d = q_bus;
	endtask
endmodule

// [bench/dcff_tb_top.sv]
// Testbench for the dual-clock nine-bit buffer: order, flags, modes, output enable.
// Assumes the read-side partner model; flag assertions sit in the design.
`timescale 1ns/10ps
`include "dcff_params.svh"
module dcff_tb_top;
	localparam int DEPTH = `DCFF_DEPTH;
	logic                    clk = 1'b0;
	logic                    rd_clk = 1'b0;
	logic                    resetn = 1'b0;
	logic [`DCFF_DATA_W-1:0] din = '0;
	logic                    wr_en_a_n = 1'b1;
	logic                    wr_en_b_or_load_n = 1'b1;
	logic                    want_oe = 1'b1;
	logic                    rd_en_a_n;
	logic                    rd_en_b_n;
	logic                    oe_n;
	logic [8:0]              dout;
	logic                    dout_oe;
	logic                    empty_n;
	logic                    almost_empty_n;
	logic                    full_n;
	logic                    almost_full_n;
	wire  [8:0]              q_bus;
	logic [8:0]              got;
	int                      mismatches = 0;
	int                      comparisons = 0;
	int                      cycles = 0;

	always #2.5 clk = ~clk;
	initial begin
		#1.3;
		forever #7.5 rd_clk = ~rd_clk;
	end

	dcff_top #(.DEPTH(DEPTH)) u_dcff_top (
		.clk              (clk),
		.resetn           (resetn),
		.rd_clk           (rd_clk),
		.din              (din),
		.wr_en_a_n        (wr_en_a_n),
		.wr_en_b_or_load_n(wr_en_b_or_load_n),
		.rd_en_a_n        (rd_en_a_n),
		.rd_en_b_n        (rd_en_b_n),
		.oe_n             (oe_n),
		.dout             (dout),
		.dout_oe          (dout_oe),
		.empty_n          (empty_n),
		.almost_empty_n   (almost_empty_n),
		.full_n           (full_n),
		.almost_full_n    (almost_full_n)
	);

	dcff_far_end u_dcff_far_end (
		.rd_clk   (rd_clk),
		.want_oe  (want_oe),
		.dout     (dout),
		.dout_oe  (dout_oe),
		.rd_en_a_n(rd_en_a_n),
		.rd_en_b_n(rd_en_b_n),
		.oe_n     (oe_n),
		.q_bus    (q_bus)
	);

	task results;
		if (mismatches == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			results;
		end
	end

	task chk1(input string n, input logic e, input logic g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %b seen %b", n, e, g);
		end
	endtask

	task chk9(input string n, input logic [8:0] e, input logic [8:0] g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	task settle;
		repeat (30) @(posedge clk);
	endtask

	task do_reset(input logic b);
		@(posedge clk);
		resetn <= 1'b0;
		wr_en_b_or_load_n <= b;
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		wr_en_b_or_load_n <= 1'b1;
		settle;
	endtask

	// Back-to-back writes of an ascending run
	task push(input int n, input logic [8:0] base);
		@(posedge clk);
		wr_en_a_n <= 1'b0;
		for (int i = 0; i < n; i++) begin
			din <= base + 9'(i);
			@(posedge clk);
		end
		wr_en_a_n <= 1'b1;
		settle;
	endtask

	task scen_order;
		wr_en_b_or_load_n <= 1'b0;
		push(4, 9'h0aa);
		chk1("empty_n", 1'b0, empty_n);
		wr_en_b_or_load_n <= 1'b1;
		push(7, 9'h1f0);
		chk1("empty_n", 1'b1, empty_n);
		chk1("almost_empty_n", 1'b0, almost_empty_n);
		push(1, 9'h1f7);
		chk1("almost_empty_n", 1'b1, almost_empty_n);
		for (int i = 0; i < 8; i++) begin
			u_dcff_far_end.pop(got);
			chk9("dout", 9'h1f0 + 9'(i), got);
		end
		settle;
		chk1("empty_n", 1'b0, empty_n);
		u_dcff_far_end.pop(got);
		chk9("dout", 9'h1f7, got);
	endtask

	task scen_full;
		push(DEPTH + 3, 9'h040);
		chk1("full_n", 1'b0, full_n);
		chk1("almost_full_n", 1'b0, almost_full_n);
		u_dcff_far_end.pop(got);
		chk9("dout", 9'h040, got);
		settle;
		chk1("full_n", 1'b1, full_n);
		for (int i = 1; i < DEPTH; i++) begin
			u_dcff_far_end.pop(got);
			chk9("dout", 9'h040 + 9'(i), got);
			if (i == 7) begin
				settle;
				chk1("almost_full_n", 1'b1, almost_full_n);
			end
		end
		settle;
		chk1("empty_n", 1'b0, empty_n);
		chk1("almost_empty_n", 1'b0, almost_empty_n);
	endtask

	task scen_oe;
		want_oe <= 1'b0;
		settle;
		chk9("q_bus", 9'hzzz, q_bus);
		want_oe <= 1'b1;
		settle;
		chk9("q_bus", 9'h07f, q_bus);
	endtask

	task scen_reset;
		push(DEPTH, 9'h100);
		do_reset(1'b1);
		chk1("full_n", 1'b1, full_n);
		chk1("almost_full_n", 1'b1, almost_full_n);
		chk1("empty_n", 1'b0, empty_n);
		chk1("almost_empty_n", 1'b0, almost_empty_n);
	endtask

	// Flag mode: load offsets of two, read all four chunks back, then see the new threshold
	task scen_pflag;
		do_reset(1'b0);
		@(posedge clk);
		wr_en_b_or_load_n <= 1'b0;
		// One chunk at a time so the read-side copy catches every update
		for (int i = 0; i < 4; i++) begin
			wr_en_a_n <= 1'b0;
			din <= i[0] ? 9'h000 : 9'h002;
			@(posedge clk);
			wr_en_a_n <= 1'b1;
			settle;
		end
		for (int i = 0; i < 4; i++) begin
			u_dcff_far_end.pop(got);
			chk9("dout", i[0] ? 9'h000 : 9'h002, got);
		end
		@(posedge clk);
		wr_en_b_or_load_n <= 1'b1;
		push(3, 9'h011);
		chk1("empty_n", 1'b1, empty_n);
		chk1("almost_empty_n", 1'b1, almost_empty_n);
		u_dcff_far_end.pop(got);
		chk9("dout", 9'h011, got);
	endtask

	initial begin
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		settle;
		scen_order;
		scen_full;
		scen_oe;
		scen_reset;
		scen_pflag;
		results;
	end
endmodule
